// file: verilog/pss_power_state_sequencer.sv
`timescale 1ns/100ps

module pss_power_state_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned RET_DEPTH = 16, // Retention memory words.
  parameter int unsigned RET_W     = 8   // Retention word width.
) (
  // Clock and reset.
  input  wire logic                          CLOCK_I,
  input  wire logic                          RSTN_I,
  // Power pin.
  input  wire logic                          CHIP_POWER_DOWN_PIN_N_I,
  // Software control.
  input  wire logic                          SLEEP_REQ_I,
  input  wire logic                          DEEP_REQ_I,
  input  wire logic [WAKE_CNT_W-1:0]         WAKE_INTERVAL_I,
  input  wire logic                          WAKE_TIMER_EN_I,
  input  wire pss_pkg::pss_wake_s            WAKE_MASK_I,
  input  wire logic [pss_pkg::NUM_BLOCKS-1:0] CLK_CTRL_I,
  input  wire logic                          WAIT_FOR_INTERRUPT_INSTRUCTION_I,
  input  wire logic                          CPU_IRQ_I,
  // Wake sources.
  input  wire pss_pkg::pss_wake_s            WAKE_EVT_I,
  // Analogue status.
  input  wire logic                          XTAL_STABLE_I,
  input  wire logic                          PLL_LOCK_I,
  // Retention memory port.
  input  wire logic                          RET_WE_I,
  input  wire logic [$clog2(RET_DEPTH)-1:0]  RET_ADDR_I,
  input  wire logic [RET_W-1:0]              RET_WDATA_I,
  output logic      [RET_W-1:0]              RET_RDATA_O,
  // Status and enables.
  output pss_pkg::pss_state_e                POWERED_STATE_O,
  output logic                               ACTIVE_O,
  output logic                               RTC_WAKE_O,
  output pss_pkg::pss_ctrl_s                 CTRL_O
);
  import pss_pkg::*;

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------

  pss_regs_s r_q;                      // Registered state.
  pss_regs_s r_d;                      // Next state.
  logic      timer_hit;                // Wake interval expired this cycle.
  logic      wake_any;                 // Any enabled wake condition.
  logic [RET_W-1:0] ret_mem [RET_DEPTH]; // Retention memory, RTC domain.
  logic [RET_W-1:0] ret_rdata_q;       // Registered read data.

  // Timer hit when the counter reaches one while sleeping with timer on.
  assign timer_hit = WAKE_TIMER_EN_I && (r_q.wake_cnt == WAKE_IVL_MIN) &&
                     (r_q.state == ST_SLEEP || r_q.state == ST_DEEP_SLEEP);
  // Masked wake events plus the timer.
  assign wake_any  = timer_hit || |(WAKE_EVT_I & WAKE_MASK_I);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------

  // Computes the next state and enables for every power state.
  always_comb begin
    r_d = r_q;
    // Counter reload or decrement while asleep.
    if (r_q.state == ST_SLEEP || r_q.state == ST_DEEP_SLEEP) begin
      if (timer_hit || r_q.wake_cnt == WAKE_CNT_RST) begin
        r_d.wake_cnt = (WAKE_INTERVAL_I == WAKE_CNT_RST) ? WAKE_IVL_MIN
                                                           : WAKE_INTERVAL_I;
      end else begin
        r_d.wake_cnt = r_q.wake_cnt - WAKE_IVL_MIN;
      end
    end else begin
      r_d.wake_cnt = WAKE_CNT_RST;
    end
    // The wake pulse lasts the one cycle after the interval runs out.
    r_d.rtc_wake = timer_hit;
    // Processor clock gate: set on wait, clear on interrupt.
    if (CPU_IRQ_I) begin
      r_d.wait_gate = 1'b0;
    end else if (WAIT_FOR_INTERRUPT_INSTRUCTION_I) begin
      r_d.wait_gate = 1'b1;
    end
    case (r_q.state)
      ST_OFF: begin
        // Leaving off always passes through wake-up to start the oscillators.
        r_d.state = ST_WAKE_UP;
      end
      ST_ON: begin
        if (DEEP_REQ_I) begin
          r_d.state = ST_DEEP_SLEEP;
        end else if (SLEEP_REQ_I) begin
          r_d.state = ST_SLEEP;
        end
      end
      ST_SLEEP, ST_DEEP_SLEEP: begin
        if (wake_any) begin
          r_d.state = ST_WAKE_UP;
        end
      end
      ST_WAKE_UP: begin
        if (XTAL_STABLE_I && PLL_LOCK_I) begin
          r_d.state = ST_ON;
        end
      end
      default: begin
        r_d.state = ST_OFF;
      end
    endcase
    // Enables follow the next state.
    r_d.ctrl.rtc_en     = 1'b1;
    r_d.ctrl.wdt_en     = (r_d.state != ST_DEEP_SLEEP);
    r_d.ctrl.main_pwr   = (r_d.state != ST_DEEP_SLEEP);
    r_d.ctrl.xtal_en    = (r_d.state == ST_WAKE_UP) || (r_d.state == ST_ON);
    r_d.ctrl.pll_en     = r_d.ctrl.xtal_en;
    r_d.ctrl.cpu_clk_en = (r_d.state == ST_ON) && !r_d.wait_gate;
    r_d.ctrl.blk_clk_en = (r_d.state == ST_ON) ? CLK_CTRL_I : CLK_EN_RST;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------

  // Power-down pin low clears r_q, like the reset input; the retention memory keeps its data.
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      r_q <= '{state: ST_OFF, wake_cnt: WAKE_CNT_RST, wait_gate: 1'b0, rtc_wake: 1'b0,
               ctrl: '{default: '0}};
    end else if (!CHIP_POWER_DOWN_PIN_N_I) begin
      r_q <= '{state: ST_OFF, wake_cnt: WAKE_CNT_RST, wait_gate: 1'b0, rtc_wake: 1'b0,
               ctrl: '{default: '0}};
    end else begin
      r_q <= r_d;
    end
  end

  // Retention memory sits in the RTC domain and is not cleared by sleep.
  always_ff @(posedge CLOCK_I) begin
    if (RET_WE_I && r_q.state == ST_ON) begin
      ret_mem[RET_ADDR_I] <= RET_WDATA_I;
    end
    ret_rdata_q <= ret_mem[RET_ADDR_I];
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  assign RET_RDATA_O     = ret_rdata_q;
  assign POWERED_STATE_O = r_q.state;
  assign ACTIVE_O        = (r_q.state == ST_ON) || (r_q.state == ST_WAKE_UP);
  assign RTC_WAKE_O      = r_q.rtc_wake;
  assign CTRL_O          = r_q.ctrl;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  property p_sleep_inactive;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_SLEEP || r_q.state == ST_DEEP_SLEEP) |-> !ACTIVE_O;
  endproperty
  a_sleep_inactive: assert property (p_sleep_inactive) else $error("Active while asleep.");

  property p_sleep_clocks;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_SLEEP) |-> (CTRL_O.blk_clk_en == CLK_EN_RST) && CTRL_O.wdt_en
                                  && !CTRL_O.cpu_clk_en;
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks) else $error("Clocks run in sleep.");

  property p_timer_wake;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (timer_hit && CHIP_POWER_DOWN_PIN_N_I) |=> RTC_WAKE_O && (r_q.state == ST_WAKE_UP);
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("Timer wake lost.");

  property p_masked_wake;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_SLEEP && !wake_any && CHIP_POWER_DOWN_PIN_N_I) |=> r_q.state == ST_SLEEP;
  endproperty
  a_masked_wake: assert property (p_masked_wake) else $error("Spurious wake.");

  property p_pd_off;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      !CHIP_POWER_DOWN_PIN_N_I |=> (r_q.state == ST_OFF) && !CTRL_O.rtc_en;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Not off after power-down.");

  property p_deep_power;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_DEEP_SLEEP) |-> !CTRL_O.main_pwr && CTRL_O.rtc_en;
  endproperty
  a_deep_power: assert property (p_deep_power) else $error("Deep sleep power wrong.");

  property p_sleep_xtal;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_SLEEP) |-> !CTRL_O.xtal_en;
  endproperty
  a_sleep_xtal: assert property (p_sleep_xtal) else $error("Crystal on in sleep.");

  property p_wakeup_en;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_WAKE_UP) |-> CTRL_O.xtal_en && CTRL_O.pll_en;
  endproperty
  a_wakeup_en: assert property (p_wakeup_en) else $error("Wake-up enables missing.");

  property p_on_gate;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_ON) && $stable(r_q.state) && $stable(CLK_CTRL_I)
        |-> CTRL_O.blk_clk_en == $past(CLK_CTRL_I);
  endproperty
  a_on_gate: assert property (p_on_gate) else $error("Block clocks wrong.");

  property p_wait_gate;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (WAIT_FOR_INTERRUPT_INSTRUCTION_I && !CPU_IRQ_I) |=> !CTRL_O.cpu_clk_en;
  endproperty
  a_wait_gate: assert property (p_wait_gate) else $error("CPU clock not gated.");

  property p_lock_wait;
    @(posedge CLOCK_I) disable iff (!RSTN_I)
      (r_q.state == ST_WAKE_UP && !(XTAL_STABLE_I && PLL_LOCK_I))
        |=> r_q.state != ST_ON;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("On before lock.");

endmodule : pss_power_state_sequencer

// file: verilog/pss_pkg.sv
package pss_pkg;

  // ---------------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------------

  // Width of the block clock enable mask.
  localparam int unsigned NUM_BLOCKS  = 8;
  // Width of the wake interval counter.
  localparam int unsigned WAKE_CNT_W  = 16;
  // Interval loaded when the programmed interval is zero.
  localparam logic [WAKE_CNT_W-1:0] WAKE_IVL_MIN = 16'h0001;
  // Cleared value of the block clock enable mask.
  localparam logic [NUM_BLOCKS-1:0] CLK_EN_RST = 8'h00;
  // Cleared value of the wake counter.
  localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = 16'h0000;

  // ---------------------------------------------------------------------------
  // Power states, one-hot
  // ---------------------------------------------------------------------------

  typedef enum logic [4:0] {
    ST_OFF        = 5'h01,
    ST_DEEP_SLEEP = 5'h02,
    ST_SLEEP      = 5'h04,
    ST_WAKE_UP    = 5'h08,
    ST_ON         = 5'h10
  } pss_state_e;

  // Wake event sources, one bit each.
  typedef struct packed {
    logic mac;   // Event from the MAC.
    logic host;  // Request from the host.
    logic ext;   // External interrupt.
  } pss_wake_s;

  // Enables sent to the analogue and clocking blocks.
  typedef struct packed {
    logic                  rtc_en;     // Real-time clock domain running.
    logic                  wdt_en;     // Watchdog timer clock running.
    logic                  main_pwr;   // Power to logic outside the RTC domain.
    logic                  xtal_en;    // Crystal oscillator enable.
    logic                  pll_en;     // PLL enables.
    logic                  cpu_clk_en; // Processor clock enable.
    logic [NUM_BLOCKS-1:0] blk_clk_en; // Per-block high-speed clock enables.
  } pss_ctrl_s;

  // Whole state of the sequencer.
  typedef struct packed {
    pss_state_e            state;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic                  wait_gate;
    logic                  rtc_wake;   // One-cycle timer wake pulse.
    pss_ctrl_s             ctrl;
  } pss_regs_s;

endpackage : pss_pkg

// file: verification/pss_far_side_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Crystal and PLL status model
// ----------------------------------------------------------------------------
module pss_far_side_model
  import pss_pkg::*;
(
  // Clock and reset.
  input  wire logic               clock_i,
  input  wire logic               rstn_i,
  // Enables from the sequencer and settle time in cycles.
  input  wire pss_pkg::pss_ctrl_s ctrl_i,
  input  wire logic [3:0]         dly_i,
  // Ready indications.
  output logic                    xtal_stable_o,
  output logic                    pll_lock_o
);
  logic [4:0] xcnt_q; // Cycles since the crystal enable rose.
  logic [4:0] pcnt_q; // Cycles since the PLL enable rose.

  // A dropped enable clears its count, so the status falls at once.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xcnt_q <= '0;
      pcnt_q <= '0;
    end else begin
      xcnt_q <= ctrl_i.xtal_en ? xcnt_q + 5'(xcnt_q < 5'h1F) : '0;
      pcnt_q <= ctrl_i.pll_en ? pcnt_q + 5'(pcnt_q < 5'h1F) : '0;
    end
  end

  // The PLL settles two cycles after the crystal.
  assign xtal_stable_o = ctrl_i.xtal_en && (xcnt_q > {1'b0, dly_i});
  assign pll_lock_o    = ctrl_i.pll_en && (pcnt_q > {1'b0, dly_i} + 5'h2);
endmodule : pss_far_side_model

// file: verification/testbench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end

module testbench;
  import pss_pkg::*;
  // Design inputs and outputs.
  logic        CLOCK_I = 0, RSTN_I = 0, CHIP_POWER_DOWN_PIN_N_I = 1;
  logic        SLEEP_REQ_I = 0, DEEP_REQ_I = 0, WAKE_TIMER_EN_I = 0, CPU_IRQ_I = 0;
  logic        WAIT_FOR_INTERRUPT_INSTRUCTION_I = 0, RET_WE_I = 0;
  logic [15:0] WAKE_INTERVAL_I = '0;
  pss_wake_s   WAKE_MASK_I = '0, WAKE_EVT_I = '0;
  logic [7:0]  CLK_CTRL_I = '0, RET_WDATA_I = '0, RET_RDATA_O, blk, rnd = 8'h55;
  logic [3:0]  RET_ADDR_I = 4'h3, dly = '0;
  logic        XTAL_STABLE_I, PLL_LOCK_I, ACTIVE_O, RTC_WAKE_O, rdy;
  pss_state_e  POWERED_STATE_O;
  pss_ctrl_s   CTRL_O;
  logic [57:0] notes[$], e; // Expected mask and value per cycle.
  int          num_errors = 0, checked = 0, cyc = 0, n;

  always #5 CLOCK_I = ~CLOCK_I;

  pss_power_state_sequencer i_dut (.CLOCK_I, .RSTN_I, .CHIP_POWER_DOWN_PIN_N_I, .SLEEP_REQ_I,
    .DEEP_REQ_I, .WAKE_INTERVAL_I, .WAKE_TIMER_EN_I, .WAKE_MASK_I, .CLK_CTRL_I,
    .WAIT_FOR_INTERRUPT_INSTRUCTION_I, .CPU_IRQ_I, .WAKE_EVT_I, .XTAL_STABLE_I, .PLL_LOCK_I,
    .RET_WE_I, .RET_ADDR_I, .RET_WDATA_I, .RET_RDATA_O, .POWERED_STATE_O, .ACTIVE_O,
    .RTC_WAKE_O, .CTRL_O);
  pss_far_side_model i_far (.clock_i(CLOCK_I), .rstn_i(RSTN_I), .ctrl_i(CTRL_O), .dly_i(dly),
    .xtal_stable_o(XTAL_STABLE_I), .pll_lock_o(PLL_LOCK_I));

  // Random source for interval, clock mask, data and settle time.
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : nxt

  // Expected outputs of a state: mask in the upper half, value below.
  function automatic logic [57:0] ex(pss_state_e s, logic [7:0] b, logic c, logic w);
    logic [28:0] m, v;
    m = {5'h1F, 2'b11, 22'h0};
    v = {s, s == ST_WAKE_UP || s == ST_ON, w, 22'h0};
    case (s)
      ST_OFF:        m[21:8] = 14'h3FFF;
      ST_DEEP_SLEEP: begin
        m[21:8] = 14'h3FFF;
        v[21] = 1'b1;
      end
      ST_SLEEP:      begin
        m[21:8] = 14'h37FF;
        v[21:20] = 2'b11;
      end
      ST_WAKE_UP:    begin
        m[18:17] = 2'b11;
        v[18:17] = 2'b11;
      end
      default:       begin
        m[16:8] = 9'h1FF;
        v[16:8] = {c, b};
      end
    endcase
    return {m, v};
  endfunction : ex

  // Inputs change one nanosecond after the rising edge.
  task step;
    @(posedge CLOCK_I);
    #1;
  endtask : step

  task note(input pss_state_e s, input logic c, input logic w);
    notes.push_back(ex(s, CLK_CTRL_I, c, w));
  endtask : note

  // Wait for a state; the sequencer may only turn on once both are ready.
  task go(input pss_state_e s);
    int k;
    k = 0;
    while (POWERED_STATE_O !== s && k < 40) begin
      rdy = XTAL_STABLE_I & PLL_LOCK_I;
      step;
      k++;
    end
    `CHK(k < 40, 1'b1)
    if (s == ST_ON) `CHK(rdy, 1'b1)
  endtask : go

  task done(input string s);
    $display("test %s finished", s);
  endtask : done

  task end_of_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Compare the oldest note with the outputs in the middle of its cycle.
  always @(negedge CLOCK_I) begin
    if (notes.size() > 0) begin
      e = notes.pop_front();
      `CHK({POWERED_STATE_O, ACTIVE_O, RTC_WAKE_O, CTRL_O, RET_RDATA_O} & e[57:29], e[28:0])
    end
  end

  // Cut a hang short.
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      $display("unexpected %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    rnd = nxt(rnd);
    CLK_CTRL_I = rnd;
    step;
    note(ST_OFF, 0, 0);
    repeat (5) step;
    RSTN_I = 1;
    go(ST_WAKE_UP);
    note(ST_WAKE_UP, 0, 0);
    go(ST_ON);
    note(ST_ON, 1, 0);
    done("power up");
    rnd = nxt(rnd);
    CLK_CTRL_I = rnd;
    step;
    note(ST_ON, 1, 0);
    WAIT_FOR_INTERRUPT_INSTRUCTION_I = 1;
    step;
    note(ST_ON, 0, 0);
    CPU_IRQ_I = 1;
    step;
    note(ST_ON, 1, 0);
    WAIT_FOR_INTERRUPT_INSTRUCTION_I = 0;
    CPU_IRQ_I = 0;
    RET_WE_I = 1;
    RET_WDATA_I = rnd;
    step;
    RET_WE_I = 0;
    done("clock gating");
    // Each source wakes only when enabled; others and deep requests are ignored.
    for (n = 0; n < 3; n++) begin
      WAKE_MASK_I = 3'b001 << n;
      WAKE_EVT_I = ~WAKE_MASK_I;
      SLEEP_REQ_I = 1;
      step;
      SLEEP_REQ_I = 0;
      DEEP_REQ_I = 1;
      note(ST_SLEEP, 0, 0);
      step;
      DEEP_REQ_I = 0;
      note(ST_SLEEP, 0, 0);
      WAKE_EVT_I = WAKE_MASK_I;
      rnd = nxt(rnd);
      dly = rnd[3:0];
      step;
      WAKE_EVT_I = '0;
      note(ST_WAKE_UP, 0, 0);
      go(ST_ON);
    end
    done("wake sources");
    // A random interval first, then a zero interval that acts as one.
    WAKE_MASK_I = '0;
    WAKE_TIMER_EN_I = 1;
    for (n = 0; n < 2; n++) begin
      WAKE_INTERVAL_I = (n == 0) ? 16'(rnd[2:0]) + 16'h2 : 16'h0;
      SLEEP_REQ_I = 1;
      step;
      SLEEP_REQ_I = 0;
      note(ST_SLEEP, 0, 0);
      repeat ((n == 0) ? WAKE_INTERVAL_I : 16'h1) begin
        step;
        note(ST_SLEEP, 0, 0);
      end
      step;
      note(ST_WAKE_UP, 0, 1);
      go(ST_ON);
    end
    WAKE_TIMER_EN_I = 0;
    done("wake timer");
    WAKE_MASK_I = 3'b001;
    DEEP_REQ_I = 1;
    SLEEP_REQ_I = 1;
    step;
    DEEP_REQ_I = 0;
    SLEEP_REQ_I = 0;
    note(ST_DEEP_SLEEP, 0, 0);
    blk = RET_WDATA_I;
    RET_WDATA_I = ~blk;
    RET_WE_I = 1;
    step;
    RET_WE_I = 0;
    WAKE_EVT_I = 3'b001;
    step;
    WAKE_EVT_I = '0;
    note(ST_WAKE_UP, 0, 0);
    go(ST_ON);
    step;
    notes.push_back({21'h0, 8'hFF, 21'h0, blk});
    done("deep sleep");
    CHIP_POWER_DOWN_PIN_N_I = 0;
    step;
    note(ST_OFF, 0, 0);
    step;
    note(ST_OFF, 0, 0);
    CHIP_POWER_DOWN_PIN_N_I = 1;
    go(ST_WAKE_UP);
    go(ST_ON);
    done("power down pin");
    step;
    step;
    end_of_test();
  end
endmodule : testbench
